/* design/slot_cap_pkg.sv */
/*
 slot capabilities register: offsets, field positions, reset values, encodings.
 assumes a 32-bit AHB-Lite register bus and word-aligned registers.
*/
package slot_cap_pkg;
    // register byte addresses
    localparam logic [11:0] SLOT_CAP_OFF   = 12'h054;
    localparam logic [11:0] SLOT_CFG_OFF   = 12'h100; // slot/lock control
    localparam logic [11:0] MSG_STAT_OFF   = 12'h104; // message counter and status
    // slot capabilities field positions
    localparam int ATTN_BTN_BIT    = 0;
    localparam int PWR_CTRL_BIT    = 1;
    localparam int LATCH_SNS_BIT   = 2;
    localparam int ATTN_IND_BIT    = 3;
    localparam int PWR_IND_BIT     = 4;
    localparam int SURPRISE_BIT    = 5;
    localparam int HOTPLUG_BIT     = 6;
    localparam int LIMIT_VAL_LSB   = 7;
    localparam int LIMIT_VAL_MSB   = 14;
    localparam int LIMIT_SCL_LSB   = 15;
    localparam int LIMIT_SCL_MSB   = 16;
    localparam int INTERLOCK_BIT   = 17;
    localparam int NO_CMD_DONE_BIT = 18;
    localparam int SLOT_ID_LSB     = 19;
    localparam int SLOT_ID_MSB     = 31;
    // control register field positions
    localparam int CFG_SLOT_BIT    = 0;  // slot implemented
    localparam int CFG_LOCK_BIT    = 1;  // locked fields read-only
    // write masks of slot capabilities
    localparam logic [31:0] LOCKED_MASK  = 32'hFFFA007F;
    localparam logic [31:0] LIMIT_MASK   = 32'h0001FF80;
    localparam logic [31:0] SLOT_CAP_RST = 32'h00000000;
    localparam logic [1:0]  SLOT_CFG_RST = 2'h2; // no slot, locked
    // power limit scale encodings
    localparam logic [1:0] SCALE_X1    = 2'h0;
    localparam logic [1:0] SCALE_XP1   = 2'h1;
    localparam logic [1:0] SCALE_XP01  = 2'h2;
    localparam logic [1:0] SCALE_XP001 = 2'h3;
    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
endpackage : slot_cap_pkg

/* design/slot_capabilities_register.sv */
/*
 slot capabilities register bank with power limit message trigger.
 assumes one AHB-Lite master, a link state input on hclk, and a message
 sender that accepts a request with msg_valid/msg_ready.
*/
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/100ps
// Behaviour
// - bits 0..4 flag attention button, power controller, latch sensor, indicators
// - with no slot implemented the whole register reads zero, ignores writes
// - bit 5 flags surprise removal permitted
// - bit 6 flags hot-plug capable slot
// - bits 14:7 read-write power limit value, reset zero
// - bits 16:15 read-write power limit scale, four decimal scales
// - a software write sends a power limit message with current fields; writes while one is pending or being sent queue one more, shared by later ones
// - link entering data-link-up sends a power limit message too
// - bit 17 flags electromechanical interlock present
// - bit 18 always zero, command completion is always notified
// - bits 31:19 physical slot number, reset zero
module slot_capabilities_register
    import slot_cap_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // link state, same clock domain
    input  wire logic        link_dl_up,
    // power limit message request
    output logic             msg_valid,
    input  wire logic        msg_ready,
    output logic      [7:0]  msg_limit_value,
    output logic      [1:0]  msg_limit_scale
);
    import slot_cap_pkg::*;

    typedef enum logic [0:0] {MSG_IDLE, MSG_SEND} msg_state_t;

    logic        wr_pend_reg;
    logic [11:0] addr_reg;
    logic [31:0] cap_reg;
    logic [1:0]  cfg_reg;
    logic        dl_up_reg;
    logic        msg_pend_reg;
    logic [7:0]  msg_count_reg;
    msg_state_t  state_reg;
    logic [31:0] cap_view;
    logic [31:0] cap_next;
    logic        cap_write;
    logic        dl_rise;
    logic        addr_ok;

    // decode of a taken address phase
    function automatic logic taken(input logic s, input logic [1:0] t, input logic r);
        taken = s && r && (t == HTRANS_NONSEQ || t == HTRANS_SEQ);
    endfunction : taken

    // bus answer, write strobe and link edge
    assign addr_ok   = taken(hsel, htrans, hready);
    assign hreadyout = 1'b1;  // zero wait states
    assign hresp     = 1'b0;  // always okay
    assign cap_write = wr_pend_reg && (addr_reg == SLOT_CAP_OFF) && cfg_reg[CFG_SLOT_BIT];
    assign dl_rise   = link_dl_up && !dl_up_reg;

    // read view gated by slot implemented
    always_comb
    begin
        cap_view = cfg_reg[CFG_SLOT_BIT] ? cap_reg : 32'h00000000;
        cap_view[NO_CMD_DONE_BIT] = 1'b0;
    end

    // locked fields skip writes while locked
    always_comb
    begin
        cap_next = cap_reg;
        if (cfg_reg[CFG_LOCK_BIT])
        begin
            cap_next = (cap_reg & ~LIMIT_MASK) | (hwdata & LIMIT_MASK);
        end
        else
        begin
            cap_next = (cap_reg & ~(LIMIT_MASK | LOCKED_MASK))
                     | (hwdata & (LIMIT_MASK | LOCKED_MASK));
        end
    end

    // address phase capture
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            addr_reg    <= 12'h000;
        end
        else
        begin
            wr_pend_reg <= addr_ok && hwrite;
            if (addr_ok)
            begin
                addr_reg <= {haddr[11:2], 2'h0};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cap_reg <= SLOT_CAP_RST;
        end
        else if (cap_write)
        begin
            cap_reg <= cap_next;
        end
    end

    // control register: slot implemented and lock
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cfg_reg <= SLOT_CFG_RST;
        end
        else if (wr_pend_reg && addr_reg == SLOT_CFG_OFF)
        begin
            cfg_reg <= hwdata[1:0];
        end
    end

    // read data registered at address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h00000000;
        end
        else if (addr_ok && !hwrite)
        begin
            case ({haddr[11:2], 2'h0})
                SLOT_CAP_OFF: hrdata <= cap_view;
                SLOT_CFG_OFF: hrdata <= {30'h0, cfg_reg};
                MSG_STAT_OFF: hrdata <= {22'h0, msg_pend_reg, msg_valid, msg_count_reg};
                default:      hrdata <= 32'h00000000;
            endcase
        end
    end

    // link state edge detect
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dl_up_reg <= 1'b0;
        end
        else
        begin
            dl_up_reg <= link_dl_up;
        end
    end

    // pending trigger; a new trigger wins over the send
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            msg_pend_reg <= 1'b0;
        end
        else if (cap_write || dl_rise)
        begin
            msg_pend_reg <= 1'b1;
        end
        else if (state_reg == MSG_IDLE)
        begin
            msg_pend_reg <= 1'b0;
        end
    end

    // message sender: latches fields, holds until accepted
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_reg       <= MSG_IDLE;
            msg_limit_value <= 8'h00;
            msg_limit_scale <= SCALE_X1;
            msg_count_reg   <= 8'h00;
        end
        else
        begin
            case (state_reg)
                MSG_IDLE:
                begin
                    if (msg_pend_reg)
                    begin
                        state_reg       <= MSG_SEND;
                        msg_limit_value <= cap_view[LIMIT_VAL_MSB:LIMIT_VAL_LSB];
                        msg_limit_scale <= cap_view[LIMIT_SCL_MSB:LIMIT_SCL_LSB];
                    end
                end
                MSG_SEND:
                begin
                    if (msg_ready)
                    begin
                        state_reg     <= MSG_IDLE;
                        msg_count_reg <= msg_count_reg + 8'h01;
                    end
                end
                default: state_reg <= MSG_IDLE;
            endcase
        end
    end

    // request stands for the whole send state
    assign msg_valid = (state_reg == MSG_SEND);

    // write leads to a request within three cycles
    property p_write_msg;
        @(posedge hclk) disable iff (!hresetn)
        cap_write && !msg_pend_reg && !msg_valid |-> ##[1:3] msg_valid;
    endproperty
    a_write_msg: assert property (p_write_msg) else $error("no message after write");

    // link up leads to a request
    property p_link_msg;
        @(posedge hclk) disable iff (!hresetn)
        dl_rise && !msg_pend_reg && !msg_valid |-> ##[1:3] msg_valid;
    endproperty
    a_link_msg: assert property (p_link_msg) else $error("no message after link up");

    property p_no_slot_zero;
        @(posedge hclk) disable iff (!hresetn)
        !cfg_reg[CFG_SLOT_BIT] |-> cap_view == 32'h00000000;
    endproperty
    a_no_slot_zero: assert property (p_no_slot_zero) else $error("view not zero");

    property p_no_cmd_done_support_zero;
        @(posedge hclk) disable iff (!hresetn) !cap_view[NO_CMD_DONE_BIT];
    endproperty
    a_no_cmd_done_support_zero: assert property (p_no_cmd_done_support_zero) else $error("bit 18 set");

    // locked fields stable under locked writes
    property p_lock_hold;
        @(posedge hclk) disable iff (!hresetn)
        cap_write && cfg_reg[CFG_LOCK_BIT]
        |=> (cap_reg & LOCKED_MASK) == $past(cap_reg & LOCKED_MASK);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("locked field changed");

    property p_limit_wr;
        @(posedge hclk) disable iff (!hresetn)
        cap_write |=> (cap_reg & LIMIT_MASK) == ($past(hwdata) & LIMIT_MASK);
    endproperty
    a_limit_wr: assert property (p_limit_wr) else $error("limit not written");

    // message fields stable while waiting
    property p_msg_stable;
        @(posedge hclk) disable iff (!hresetn)
        msg_valid && !msg_ready
        |=> msg_valid && $stable(msg_limit_value) && $stable(msg_limit_scale);
    endproperty
    a_msg_stable: assert property (p_msg_stable) else $error("message dropped");

    property p_slot_id_wr;
        @(posedge hclk) disable iff (!hresetn)
        cap_write && !cfg_reg[CFG_LOCK_BIT]
        |=> cap_reg[SLOT_ID_MSB:SLOT_ID_LSB] == $past(hwdata[SLOT_ID_MSB:SLOT_ID_LSB]);
    endproperty
    a_slot_id_wr: assert property (p_slot_id_wr) else $error("slot id not written");

    // steps of one message: trigger, pending, request
    sequence s_fresh_write;
        cap_write && !msg_pend_reg && !msg_valid;
    endsequence

    sequence s_fresh_link;
        dl_rise && !msg_pend_reg && !msg_valid;
    endsequence

    sequence s_pend_send;
        msg_pend_reg ##1 msg_valid;
    endsequence

    property p_write_steps;
        @(posedge hclk) disable iff (!hresetn)
        s_fresh_write |=> s_pend_send;
    endproperty
    a_write_steps: assert property (p_write_steps) else $error("write did not send");

    // link up goes pending, then requests
    property p_link_steps;
        @(posedge hclk) disable iff (!hresetn)
        s_fresh_link |=> s_pend_send;
    endproperty
    a_link_steps: assert property (p_link_steps) else $error("link up did not send");

    property p_msg_current;
        @(posedge hclk) disable iff (!hresetn)
        msg_pend_reg && state_reg == MSG_IDLE
        |=> msg_limit_value == $past(cap_view[LIMIT_VAL_MSB:LIMIT_VAL_LSB])
            && msg_limit_scale == $past(cap_view[LIMIT_SCL_MSB:LIMIT_SCL_LSB]);
    endproperty
    a_msg_current: assert property (p_msg_current) else $error("stale message fields");

    // cap writes dropped without a slot
    property p_no_slot_keep;
        @(posedge hclk) disable iff (!hresetn)
        wr_pend_reg && addr_reg == SLOT_CAP_OFF && !cfg_reg[CFG_SLOT_BIT]
        |=> $stable(cap_reg);
    endproperty
    a_no_slot_keep: assert property (p_no_slot_keep) else $error("slot off but written");

    property p_read_view;
        @(posedge hclk) disable iff (!hresetn)
        addr_ok && !hwrite && {haddr[11:2], 2'h0} == SLOT_CAP_OFF
        |=> hrdata == $past(cap_view);
    endproperty
    a_read_view: assert property (p_read_view) else $error("read data not the view");

    property p_count_step;
        @(posedge hclk) disable iff (!hresetn)
        msg_valid && msg_ready |=> msg_count_reg == $past(msg_count_reg) + 8'h01;
    endproperty
    a_count_step: assert property (p_count_step) else $error("message count off");
endmodule : slot_capabilities_register

/* bench/slot_msg_sink.sv */
/*
 partner model: device in the slot taking power limit requests.
 assumes one request at a time on msg_valid/msg_ready, same clock.
*/
`timescale 1ns/100ps
module slot_msg_sink
(
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // request port
    input  wire logic       msg_valid,
    output logic            msg_ready,
    input  wire logic [7:0] msg_limit_value,
    input  wire logic [1:0] msg_limit_scale,
    // stall mode and capture
    input  wire logic       slow,
    output int              rx_cnt,
    output logic      [9:0] rx_msg
);
    // accept requests, ready only every other cycle when slow
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            msg_ready <= 1'b0;
            rx_cnt    <= 0;
            rx_msg    <= 10'h000;
        end
        else
        begin
            msg_ready <= slow ? ~msg_ready : 1'b1;
            if (msg_valid && msg_ready)
            begin
                rx_cnt <= rx_cnt + 1;
                rx_msg <= {msg_limit_value, msg_limit_scale};
            end
        end
    end
endmodule : slot_msg_sink

/* bench/slot_capabilities_register_tb.sv */
/*
 testbench: slot enable, lock, field access and power limit messages.
 assumes a zero-wait slave and the slot_msg_sink partner.
*/
`timescale 1ns/100ps
module slot_capabilities_register_tb;
    import slot_cap_pkg::*;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, link_dl_up = 0, slow = 0;
    logic        hready, hresp, msg_valid, msg_ready;
    logic [11:0] haddr  = 12'h000;
    logic [1:0]  htrans = 2'h0, ms;
    logic [2:0]  hsize  = 3'h2;
    logic [7:0]  mv;
    logic [9:0]  rx_msg;
    logic [9:0]  exp_q[$];
    logic [31:0] hwdata = 32'h0, hrdata, d, r, cap = 32'h0;
    bit          lck = 1;
    int          rx_cnt, n0, error_cnt = 0, total_checks = 0, seed = 91;

    // clock
    always #12.5 hclk = ~hclk;

    slot_capabilities_register u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
        .link_dl_up(link_dl_up), .msg_valid(msg_valid), .msg_ready(msg_ready),
        .msg_limit_value(mv), .msg_limit_scale(ms));
    slot_msg_sink u_sink (.hclk(hclk), .hresetn(hresetn), .msg_valid(msg_valid),
        .msg_ready(msg_ready), .msg_limit_value(mv), .msg_limit_scale(ms),
        .slow(slow), .rx_cnt(rx_cnt), .rx_msg(rx_msg));

    task summarize;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            $display("Error at %0t got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk

    // bounded wait for hready at a rising edge
    task wt_rdy;
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1)
        begin
            error_cnt++;
            summarize();
        end
    endtask : wt_rdy

    // one single-word transfer, read data into r
    task bus(input logic [11:0] a, input logic w, input logic [31:0] dd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        wt_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= dd;
        wt_rdy();
        r = hrdata;
    endtask : bus

    // exactly one message since n0, with the expected fields
    task msg_chk(input logic [9:0] e);
        exp_q.push_back(e);
        for (int n = 0; n < 40 && rx_cnt == n0; n++)
            @(posedge hclk);
        if (rx_cnt == n0)
        begin
            error_cnt++;
            summarize();
        end
        repeat (8) @(posedge hclk);
        chk(32'(rx_cnt), 32'(n0 + 1));
        chk({22'h0, rx_msg}, {22'h0, exp_q.pop_front()});
    endtask : msg_chk

    initial
    begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        // no slot: blank, writes ignored
        n0 = rx_cnt;
        bus(SLOT_CAP_OFF, 1'b1, 32'hFFFFFFFF);
        bus(SLOT_CAP_OFF, 1'b0, 32'h0);
        chk(r, 32'h0);
        chk(32'(rx_cnt), 32'(n0));
        for (int k = 0; k < 2; k++)
        begin
            lck = (k == 0);
            slow <= k[0];
            bus(SLOT_CFG_OFF, 1'b1, {30'h0, lck, 1'b1});
            for (int i = 0; i < 4; i++)
            begin
                d = (i == 3) ? 32'hFFFFFFFF : $random(seed);
                d[16:15] = i[1:0];
                n0 = rx_cnt;
                bus(SLOT_CAP_OFF, 1'b1, d);
                // lock keeps presence and slot fields
                cap = lck ? (cap & ~LIMIT_MASK) | (d & LIMIT_MASK)
                          : d & (LOCKED_MASK | LIMIT_MASK);
                msg_chk({cap[14:7], cap[16:15]});
                bus(SLOT_CAP_OFF, 1'b0, 32'h0);
                chk(r, cap);
            end
        end
        // link entering data-link-up
        n0 = rx_cnt;
        link_dl_up <= 1'b1;
        msg_chk({cap[14:7], cap[16:15]});
        link_dl_up <= 1'b0;
        repeat (10) @(posedge hclk);
        chk(32'(rx_cnt), 32'(n0 + 1));
        bus(12'h0F0, 1'b0, 32'h0);
        chk(r, 32'h0);
        // slot cleared then restored
        bus(SLOT_CFG_OFF, 1'b1, 32'h0);
        bus(SLOT_CAP_OFF, 1'b0, 32'h0);
        chk(r, 32'h0);
        bus(SLOT_CFG_OFF, 1'b1, 32'h1);
        bus(SLOT_CAP_OFF, 1'b0, 32'h0);
        chk(r, cap);
        // status: messages sent so far, none pending
        bus(MSG_STAT_OFF, 1'b0, 32'h0);
        chk(r, 32'(n0 + 1));
        chk(32'(hresp), 32'h0);
        // mid-run reset: control and fields back to reset values
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        bus(SLOT_CFG_OFF, 1'b0, 32'h0);
        chk(r, 32'(SLOT_CFG_RST));
        bus(SLOT_CFG_OFF, 1'b1, 32'h1);
        bus(SLOT_CAP_OFF, 1'b0, 32'h0);
        chk(r, SLOT_CAP_RST);
        // on-board device: slot number left zero
        n0 = rx_cnt;
        cap = 32'h0007FFFF & (LOCKED_MASK | LIMIT_MASK);
        bus(SLOT_CAP_OFF, 1'b1, 32'h0007FFFF);
        msg_chk({cap[14:7], cap[16:15]});
        bus(SLOT_CAP_OFF, 1'b0, 32'h0);
        chk(r, cap);
        summarize();
    end

    // hang guard
    initial
    begin
        #2500000;
        error_cnt++;
        summarize();
    end
endmodule : slot_capabilities_register_tb
